// [core/clkpath_consts.vh]
`ifndef CLKPATH_CONSTS_VH
`define CLKPATH_CONSTS_VH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_UPDATE        14'h0005
`define IDX_DIST_GATE     14'h0405
`define IDX_RF_PWR        14'h0408
`define IDX_SYNC_MASK     14'h0500
`define IDX_STATUS        14'h0410

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define RF_PWR_PD1        0
`define RF_PWR_PD2        1
`define RF_PWR_DUAL       2
`define RF_PWR_STARTUP    4
`define DIST_GATE_BIT     3
`define MASK_CH1          5
`define MASK_CH3          7
`define ST_FB_SEEN        0
`define ST_RF1_PD         1
`define ST_RF2_PD         2
`define ST_LOCKED         3
`define ST_RUN_LO         5

// ------------------------------------------------------------------
// Writable bits, reset values, commit code
// ------------------------------------------------------------------
`define RF_PWR_WMASK      8'h17
`define SYNC_MASK_WMASK   8'hE0
`define DIST_GATE_WMASK   8'h08
`define RF_PWR_RESET      8'h02
`define SYNC_MASK_RESET   8'h00
`define DIST_GATE_RESET   8'h00
`define UPDATE_CODE       8'h01

`endif

// [core/pin_sync.v]
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge clk) begin
        if (rst) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          lvl_r <= 1'b0;
        end else begin
          s1_r <= pin[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Level moves only when the two late stages agree
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level[i] = lvl_r;
    end
  endgenerate

endmodule

// [core/channel_hold.v]
module channel_hold (
  input  wire clk,
  input  wire rst,
  input  wire mask,
  input  wire sync_evt,
  output reg  run_r,
  output reg  sync_rst_r
);

  always @(posedge clk) begin
    if (rst) begin
      run_r      <= 1'b0;
      sync_rst_r <= 1'b0;
    end else if (mask) begin
      // Masked: released from the hold, every sync event dropped
      run_r      <= 1'b1;
      sync_rst_r <= 1'b0;
    end else if (sync_evt) begin
      run_r      <= 1'b1;
      sync_rst_r <= 1'b1;
    end else begin
      sync_rst_r <= 1'b0;
    end
  end

endmodule

// [core/clock_path_ctrl.v]
// Local design decision: the APB slave port.
`include "clkpath_consts.vh"

module clock_path_ctrl (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [15:0] PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        FB_DETECT,
  input  wire        LOOP_LOCKED,
  input  wire        SYNC_IN,
  input  wire [3:1]  DRV_EN_REQ,
  output reg         RF1_PD,
  output reg         RF2_PD,
  output wire [3:1]  CH_RUN,
  output wire [3:1]  CH_SYNC_RST,
  output reg  [3:1]  DRV_EN
);

  // ----------------------------------------------------------------
  // Register state: staged copies and committed copies
  // ----------------------------------------------------------------
  reg  [7:0]  rf_pwr_stage_r;
  reg  [7:0]  rf_pwr_act_r;
  reg  [7:0]  mask_stage_r;
  reg  [7:0]  mask_act_r;
  reg  [7:0]  gate_stage_r;
  reg  [7:0]  gate_act_r;
  reg         fb_seen_r;
  reg         sync_prev_r;
  reg         sync_evt_r;

  wire [13:0] idx;
  wire        aligned;
  wire        setup;
  wire        access;
  wire        wr_done;
  wire        hit_update;
  wire        hit_gate;
  wire        hit_rf;
  wire        hit_mask;
  wire        hit_status;
  wire        mapped;
  wire        commit;
  wire        fb_lvl;
  wire        lock_lvl;
  wire        sync_lvl;
  wire        hold;
  wire        pd_both;
  wire        sync_ok;
  wire        sync_rise;
  wire        wr_rf;
  wire        wr_mask;
  wire        wr_gate;
  wire [7:0]  wr_byte;
  wire [3:1]  ch_mask;
  wire [7:0]  status;

  reg  [31:0] prdata_nxt;
  reg         pready_nxt;
  reg         pslverr_nxt;
  reg         rf1_pd_nxt;
  reg         rf2_pd_nxt;
  reg  [7:0]  rf_pwr_stage_nxt;
  reg  [7:0]  mask_stage_nxt;
  reg  [7:0]  gate_stage_nxt;

  // ----------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (3)
  ) u_pins (
    .clk   (CLK),
    .rst   (RST),
    .pin   ({SYNC_IN, LOOP_LOCKED, FB_DETECT}),
    .level ({sync_lvl, lock_lvl, fb_lvl})
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx        = PADDR[15:2];
  assign aligned    = (PADDR[1:0] == 2'h0);
  assign setup      = PSEL & ~PENABLE;
  assign access     = PSEL & PENABLE & PREADY;
  assign hit_update = aligned & (idx == `IDX_UPDATE);
  assign hit_gate   = aligned & (idx == `IDX_DIST_GATE);
  assign hit_rf     = aligned & (idx == `IDX_RF_PWR);
  assign hit_mask   = aligned & (idx == `IDX_SYNC_MASK);
  assign hit_status = aligned & (idx == `IDX_STATUS);
  assign mapped     = hit_update | hit_gate | hit_rf | hit_mask |
                      hit_status;
  assign wr_done    = access & PWRITE & mapped & PSTRB[0];
  // Per-register write strobes; reserved bits are masked on store
  assign wr_rf      = wr_done & hit_rf;
  assign wr_mask    = wr_done & hit_mask;
  assign wr_gate    = wr_done & hit_gate;
  assign wr_byte    = PWDATA[7:0];

  // Commit only on the exact code; other values leave staging pending
  assign commit = wr_done & hit_update &
                  (wr_byte == `UPDATE_CODE);

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Ready follows each setup cycle; no further wait states
  always @* begin
    pready_nxt  = setup;
    pslverr_nxt = setup & ~mapped;
  end

  always @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= pready_nxt;
      PSLVERR <= pslverr_nxt;
      PRDATA  <= pready_nxt ? prdata_nxt : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  assign status = {
    CH_RUN,
    1'b0,
    lock_lvl,
    RF2_PD,
    RF1_PD,
    fb_seen_r
  };

  always @* begin
    prdata_nxt = 32'h00000000;
    if (~PWRITE) begin
      if (hit_rf) begin
        prdata_nxt = {24'h000000, rf_pwr_stage_r};
      end else if (hit_mask) begin
        prdata_nxt = {24'h000000, mask_stage_r};
      end else if (hit_gate) begin
        prdata_nxt = {24'h000000, gate_stage_r};
      end else if (hit_status) begin
        prdata_nxt = {24'h000000, status};
      end else begin
        prdata_nxt = 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Staging registers
  // ----------------------------------------------------------------
  // Reserved bits are never stored, so they always read zero
  always @* begin
    rf_pwr_stage_nxt = rf_pwr_stage_r;
    mask_stage_nxt   = mask_stage_r;
    gate_stage_nxt   = gate_stage_r;
    if (wr_rf) begin
      rf_pwr_stage_nxt = wr_byte & `RF_PWR_WMASK;
    end
    if (wr_mask) begin
      mask_stage_nxt = wr_byte & `SYNC_MASK_WMASK;
    end
    if (wr_gate) begin
      gate_stage_nxt = wr_byte & `DIST_GATE_WMASK;
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      rf_pwr_stage_r <= `RF_PWR_RESET;
      mask_stage_r   <= `SYNC_MASK_RESET;
      gate_stage_r   <= `DIST_GATE_RESET;
    end else begin
      rf_pwr_stage_r <= rf_pwr_stage_nxt;
      mask_stage_r   <= mask_stage_nxt;
      gate_stage_r   <= gate_stage_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Committed copies
  // ----------------------------------------------------------------
  // Staged settings steer nothing until the update write
  always @(posedge CLK) begin
    if (RST) begin
      rf_pwr_act_r <= `RF_PWR_RESET;
      mask_act_r   <= `SYNC_MASK_RESET;
      gate_act_r   <= `DIST_GATE_RESET;
    end else if (commit) begin
      rf_pwr_act_r <= rf_pwr_stage_r;
      mask_act_r   <= mask_stage_r;
      gate_act_r   <= gate_stage_r;
    end
  end

  // ----------------------------------------------------------------
  // RF divider power-down
  // ----------------------------------------------------------------
  // Detection is sticky; only reset rearms the start-up hold
  always @(posedge CLK) begin
    if (RST) begin
      fb_seen_r <= 1'b0;
    end else if (fb_lvl) begin
      fb_seen_r <= 1'b1;
    end
  end

  assign hold = ~rf_pwr_act_r[`RF_PWR_STARTUP] & ~fb_seen_r;
  assign pd_both = hold | rf_pwr_act_r[`RF_PWR_DUAL];

  // Each divider adds its own bit to the shared power-down
  always @* begin
    rf1_pd_nxt = pd_both | rf_pwr_act_r[`RF_PWR_PD1];
    rf2_pd_nxt = pd_both | rf_pwr_act_r[`RF_PWR_PD2];
  end

  // Out of reset both dividers read powered down until decided
  always @(posedge CLK) begin
    if (RST) begin
      RF1_PD <= 1'b1;
      RF2_PD <= 1'b1;
    end else begin
      RF1_PD <= rf1_pd_nxt;
      RF2_PD <= rf2_pd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sync event detection and gating
  // ----------------------------------------------------------------
  // Without the gate bit a sync passes only while the loop is locked
  assign sync_ok   = gate_act_r[`DIST_GATE_BIT] | lock_lvl;
  // Edge taken on the filtered level, so single-cycle pin glitches cannot repeat it
  assign sync_rise = sync_lvl & ~sync_prev_r;

  always @(posedge CLK) begin
    if (RST) begin
      sync_prev_r <= 1'b0;
      sync_evt_r  <= 1'b0;
    end else begin
      sync_prev_r <= sync_lvl;
      sync_evt_r  <= sync_rise & sync_ok;
    end
  end

  // ----------------------------------------------------------------
  // Output channels 1 to 3
  // ----------------------------------------------------------------
  // Mask field holds channel 1 at its lowest bit
  assign ch_mask = mask_act_r[`MASK_CH3:`MASK_CH1];

  // Release is two clocks after the commit write, not truly asynchronous
  genvar c;
  generate
    for (c = 1; c <= 3; c = c + 1) begin : g_ch
      channel_hold u_hold (
        .clk        (CLK),
        .rst        (RST),
        .mask       (ch_mask[c]),
        .sync_evt   (sync_evt_r),
        .run_r      (CH_RUN[c]),
        .sync_rst_r (CH_SYNC_RST[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Driver enables
  // ----------------------------------------------------------------
  // Driver enables follow their own request only, never the mask
  always @(posedge CLK) begin
    if (RST) begin
      DRV_EN <= 3'h0;
    end else begin
      DRV_EN <= DRV_EN_REQ;
    end
  end

endmodule

// [bench/clock_path_ctrl_asserts.sv]
module clock_path_ctrl_asserts (
  input wire        CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        RF1_PD,
  input wire        RF2_PD,
  input wire [3:1]  DRV_EN_REQ,
  input wire [3:1]  CH_RUN,
  input wire [3:1]  CH_SYNC_RST,
  input wire [3:1]  DRV_EN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_pd_rst; $past(RST) |-> RF1_PD && RF2_PD; endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("rf not held");
  property p_drv; !$past(RST) |-> DRV_EN == $past(DRV_EN_REQ); endproperty
  a_drv: assert property (p_drv) else $error("driver enable moved");
  property p_run; !$past(RST) |-> (CH_RUN & $past(CH_RUN)) == $past(CH_RUN);
  endproperty
  a_run: assert property (p_run) else $error("channel re-held");
  property p_sync; CH_SYNC_RST != 3'h0 |=> CH_SYNC_RST == 3'h0; endproperty
  a_sync: assert property (p_sync) else $error("sync pulse long");
  property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_rdy1; PREADY |=> !PREADY; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready long");
  property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle; !PREADY || PSLVERR |-> PRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
endmodule

// [bench/clock_path_ctrl_test.sv]
`include "clkpath_consts.vh"
module clock_path_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        FB_DETECT, LOOP_LOCKED, SYNC_IN, RF1_PD, RF2_PD, err;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, v;
  logic [3:0]  PSTRB;
  logic [3:1]  DRV_EN_REQ, CH_RUN, CH_SYNC_RST, DRV_EN, seen;
  integer      err_count, compares, seed, i;

  clock_path_ctrl dut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR, .FB_DETECT, .LOOP_LOCKED,
    .SYNC_IN, .DRV_EN_REQ, .RF1_PD, .RF2_PD, .CH_RUN, .CH_SYNC_RST, .DRV_EN);

  initial begin
    CLK = 0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) DRV_EN_REQ <= 3'($random(seed));
  initial begin
    #2000000;
    err_count++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task apb(input logic wr, input logic [13:0] idx, input logic [31:0] d);
    integer n;
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      err_count++;
      end_of_test;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task rdchk(input logic [13:0] idx, input logic [31:0] e, input logic ee);
    apb(0, idx, 32'h0);
    chk(rd, e);
    chk(err, ee);
  endtask
  task commit;
    apb(1, `IDX_UPDATE, 32'h01);
    repeat (3) @(posedge CLK);
  endtask
  task sync_ev;
    seen = 0;
    @(posedge CLK);
    SYNC_IN <= 1;
    repeat (16) begin
      @(posedge CLK);
      #1 seen = seen | CH_SYNC_RST;
    end
    @(posedge CLK);
    SYNC_IN <= 0;
    repeat (8) @(posedge CLK);
  endtask
  // Divider power-down pair {second, first}; hold waits for feedback
  function logic [1:0] pd_exp(input logic [7:0] r, input logic fb);
    logic h;
    h = ~r[4] & ~fb;
    return {h | r[2] | r[1], h | r[2] | r[0]};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 47876;
    err_count = 0;
    compares = 0;
    {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 51'h0};
    {FB_DETECT, LOOP_LOCKED, SYNC_IN} = 3'h0;
    PSTRB = 4'hF;
    repeat (3) @(posedge CLK);
    RST <= 0;
    rdchk(`IDX_RF_PWR, 32'h02, 0);
    rdchk(`IDX_SYNC_MASK, 32'h00, 0);
    rdchk(14'h0123, 32'h00, 1);
    chk({RF2_PD, RF1_PD}, 2'b11);
    $display("reset test done");
    apb(1, `IDX_RF_PWR, 32'h10);
    apb(1, `IDX_UPDATE, 32'h02);
    repeat (4) @(posedge CLK);
    chk({RF2_PD, RF1_PD}, 2'b11);
    commit;
    chk({RF2_PD, RF1_PD}, 2'b00);
    for (i = 0; i < 8; i++) begin
      v = $random(seed) | 32'h10;
      apb(1, `IDX_RF_PWR, v);
      commit;
      chk({RF2_PD, RF1_PD}, pd_exp(v[7:0], 0));
      rdchk(`IDX_RF_PWR, v & `RF_PWR_WMASK, 0);
    end
    apb(1, `IDX_RF_PWR, 32'h00);
    commit;
    chk({RF2_PD, RF1_PD}, pd_exp(8'h00, 0));
    FB_DETECT <= 1;
    repeat (8) @(posedge CLK);
    chk({RF2_PD, RF1_PD}, pd_exp(8'h00, 1));
    rdchk(`IDX_STATUS, 32'h01, 0);
    $display("power test done");
    apb(1, `IDX_SYNC_MASK, 32'h80);
    repeat (4) @(posedge CLK);
    chk(CH_RUN, 3'b000);
    commit;
    chk(CH_RUN, 3'b100);
    @(posedge CLK);
    seen = DRV_EN_REQ;
    #1 chk(DRV_EN, seen);
    sync_ev;
    chk(seen, 3'b000);
    apb(1, `IDX_DIST_GATE, 32'h08);
    commit;
    sync_ev;
    chk(seen, 3'b011);
    chk(CH_RUN, 3'b111);
    $display("mask test done");
    @(posedge CLK);
    RST <= 1;
    repeat (3) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    chk(CH_RUN, 3'b000);
    apb(1, `IDX_SYNC_MASK, 32'h60);
    commit;
    chk(CH_RUN, 3'b011);
    LOOP_LOCKED <= 1;
    repeat (8) @(posedge CLK);
    sync_ev;
    chk(seen, 3'b100);
    chk({RF2_PD, RF1_PD}, pd_exp(`RF_PWR_RESET, 1));
    PSTRB <= 4'h0;
    apb(1, `IDX_RF_PWR, 32'hFF);
    PSTRB <= 4'hF;
    rdchk(`IDX_RF_PWR, `RF_PWR_RESET, 0);
    apb(1, `IDX_STATUS, 32'hFF);
    chk(err, 0);
    rdchk(`IDX_STATUS, 32'hED, 0);
    $display("second reset test done");
    end_of_test;
  end
endmodule

bind clock_path_ctrl clock_path_ctrl_asserts chk_i (.CLK, .RST, .PSEL,
  .PENABLE, .PRDATA, .PREADY, .PSLVERR, .RF1_PD, .RF2_PD, .DRV_EN_REQ,
  .CH_RUN, .CH_SYNC_RST, .DRV_EN);
